// ==== hw/tdc_ctrl.sv ====
/*
 * Multi-function time delay controller: one relay output driven from
 * power-sense and trigger-switch pins by a selected timing function.
 * Assumes mode_sel and delay_count are static while power is present.
 */
// Contract
// - on-delay: energise after full delay from power
// - on-delay: release when power drops
// - cycle-open: off delay, then on/off repeating
// - interval: energise and start timing on power
// - interval: release on expiry or power loss
// - power-driven functions ignore the trigger switch
// - off-delay: energise immediately on switch close
// - off-delay: time from opening, then release
// - off-delay: reclose clears time, restarts later
// - off-delay retrigger keeps output energised
// - trigger functions release on power loss
// - one-shot: triggers accepted only with power
// - one-shot: each trigger energises, starts timing
// - one-shot: expiry releases unless retriggered
// - one-shot: fast cycling holds output on
// - cycle-closed: on at once, then alternate
// - pulse: one fixed pulse after delay
// - pulse: repeat only after power cycle
`timescale 1ns/100ps

module tdc_ctrl
    import tdc_pkg::*;
#(
    parameter int SETTLE_CYC = DEBOUNCE_CYC,
    parameter int PULSE_LEN  = PULSE_CYC
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             power_pin,
    input  wire logic             trigger_pin,
    input  wire tdc_pkg::tdc_mode_t mode_sel,
    input  wire logic [tdc_pkg::CNT_W-1:0] delay_count,
    output logic                  relay_output,
    output logic                  timing_active
);
    import tdc_pkg::*;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    tdc_inputs_t  in_c;
    logic         trig_prev;

    // Both pins synchronised and debounced
    tdc_debounce #(.SETTLE_CYC(SETTLE_CYC)) u_db_power (
        .clk   (clk),
        .rst   (rst),
        .pin   (power_pin),
        .level (in_c.power)
    );

    tdc_debounce #(.SETTLE_CYC(SETTLE_CYC)) u_db_trig (
        .clk   (clk),
        .rst   (rst),
        .pin   (trigger_pin),
        .level (in_c.trig)
    );

    logic trig_rise;

    // Trigger close edge, qualified by power
    assign trig_rise = in_c.power & in_c.trig & ~trig_prev;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    tdc_state_t         state;
    tdc_state_t         next_state;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   next_cnt;
    logic               next_relay;
    logic               next_timing;
    logic               expired;
    logic               pulse_end;

    // Terminal count compare
    assign expired   = (cnt + 1'b1 >= delay_count);
    assign pulse_end = (cnt == CNT_W'(PULSE_LEN - 1));

    // Next state, counter and output
    always_comb
    begin
        next_state  = state;
        next_cnt    = cnt + 1'b1;
        next_relay  = relay_output;
        next_timing = 1'b0;
        if (!in_c.power)
        begin
            // Power loss clears all timing, shelf state
            next_state = TDC_ST_IDLE;
            next_cnt   = '0;
            next_relay = 1'b0;
        end
        else
        begin
            case (mode_sel)
            // Power-driven functions never look at the trigger
            TDC_FN_ON_DELAY:
            begin
                case (state)
                TDC_ST_IDLE:
                begin
                    next_state = TDC_ST_WAIT;
                    next_cnt   = '0;
                end
                TDC_ST_WAIT:
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_DONE;
                        next_relay = 1'b1;
                    end
                end
                default:
                begin
                    next_cnt   = cnt;
                end
                endcase
            end
            TDC_FN_CYCLE_OPEN, TDC_FN_CYCLE_CLOSED:
            begin
                case (state)
                TDC_ST_IDLE:
                begin
                    next_cnt = '0;
                    if (mode_sel == TDC_FN_CYCLE_CLOSED)
                    begin
                        next_state = TDC_ST_ON;
                        next_relay = 1'b1;
                    end
                    else
                    begin
                        next_state = TDC_ST_OFF;
                    end
                end
                TDC_ST_ON:
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_OFF;
                        next_relay = 1'b0;
                        next_cnt   = '0;
                    end
                end
                default:
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_ON;
                        next_relay = 1'b1;
                        next_cnt   = '0;
                    end
                end
                endcase
            end
            TDC_FN_INTERVAL:
            begin
                case (state)
                TDC_ST_IDLE:
                begin
                    next_state = TDC_ST_ON;
                    next_relay = 1'b1;
                    next_cnt   = '0;
                end
                TDC_ST_ON:
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_DONE;
                        next_relay = 1'b0;
                    end
                end
                default:
                begin
                    next_cnt = cnt;
                end
                endcase
            end
            TDC_FN_OFF_DELAY:
            begin
                next_cnt = '0;
                if (in_c.trig)
                begin
                    // Closed switch holds output and clears time
                    next_state = TDC_ST_HOLD;
                    next_relay = 1'b1;
                end
                else if (state == TDC_ST_HOLD || state == TDC_ST_OFF)
                begin
                    next_state = TDC_ST_OFF;
                    next_cnt   = (state == TDC_ST_HOLD) ? '0 : cnt + 1'b1;
                    if (state == TDC_ST_OFF && expired)
                    begin
                        next_state = TDC_ST_IDLE;
                        next_relay = 1'b0;
                    end
                end
            end
            TDC_FN_ONE_SHOT:
            begin
                if (trig_rise)
                begin
                    // Each activation restarts the full delay
                    next_state = TDC_ST_ON;
                    next_relay = 1'b1;
                    next_cnt   = '0;
                end
                else if (state == TDC_ST_ON)
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_IDLE;
                        next_relay = 1'b0;
                    end
                end
                else
                begin
                    next_cnt = '0;
                end
            end
            TDC_FN_PULSE:
            begin
                case (state)
                TDC_ST_IDLE:
                begin
                    next_state = TDC_ST_WAIT;
                    next_cnt   = '0;
                end
                TDC_ST_WAIT:
                begin
                    if (expired)
                    begin
                        next_state = TDC_ST_ON;
                        next_relay = 1'b1;
                        next_cnt   = '0;
                    end
                end
                TDC_ST_ON:
                begin
                    if (pulse_end)
                    begin
                        next_state = TDC_ST_DONE;
                        next_relay = 1'b0;
                    end
                end
                default:
                begin
                    next_cnt = cnt;
                end
                endcase
            end
            default:
            begin
                next_state = TDC_ST_IDLE;
                next_cnt   = '0;
                next_relay = 1'b0;
            end
            endcase
            next_timing = (next_state == TDC_ST_WAIT) ||
                          (next_state == TDC_ST_ON)   ||
                          (next_state == TDC_ST_OFF);
        end
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state         <= TDC_ST_IDLE;
            cnt           <= '0;
            relay_output  <= 1'b0;
            timing_active <= 1'b0;
            trig_prev     <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            cnt           <= next_cnt;
            relay_output  <= next_relay;
            timing_active <= next_timing;
            trig_prev     <= in_c.trig;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_power_release;
        !in_c.power |=> !relay_output;
    endproperty
    a_power_release: assert property (p_power_release)
        else $error("relay on without power");

    property p_interval_start;
        in_c.power && mode_sel == TDC_FN_INTERVAL && state == TDC_ST_IDLE
            |=> relay_output;
    endproperty
    a_interval_start: assert property (p_interval_start)
        else $error("interval did not energise");

    property p_off_close;
        in_c.power && in_c.trig && mode_sel == TDC_FN_OFF_DELAY
            |=> relay_output;
    endproperty
    a_off_close: assert property (p_off_close)
        else $error("off-delay not energised on close");

    property p_off_hold;
        mode_sel == TDC_FN_OFF_DELAY && in_c.power && relay_output
            && state == TDC_ST_OFF && in_c.trig |=> relay_output;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("off-delay retrigger dropped output");

    property p_shot_trig;
        mode_sel == TDC_FN_ONE_SHOT && trig_rise
            |=> relay_output && cnt == '0;
    endproperty
    a_shot_trig: assert property (p_shot_trig)
        else $error("one-shot trigger not taken");

    property p_ondelay_early;
        mode_sel == TDC_FN_ON_DELAY && state == TDC_ST_WAIT && !expired
            |=> !relay_output;
    endproperty
    a_ondelay_early: assert property (p_ondelay_early)
        else $error("on-delay energised early");

    property p_pulse_once;
        mode_sel == TDC_FN_PULSE && state == TDC_ST_DONE && in_c.power
            |=> !relay_output && state == TDC_ST_DONE;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("pulse repeated without power cycle");

    property p_pulse_width;
        mode_sel == TDC_FN_PULSE && state == TDC_ST_ON && pulse_end
            && in_c.power |=> !relay_output;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse did not end");

    property p_cycle_flip;
        (mode_sel == TDC_FN_CYCLE_OPEN || mode_sel == TDC_FN_CYCLE_CLOSED)
            && in_c.power && state != TDC_ST_IDLE && expired
            |=> relay_output != $past(relay_output);
    endproperty
    a_cycle_flip: assert property (p_cycle_flip)
        else $error("cycle phase did not toggle");

endmodule // tdc_ctrl

// ==== hw/tdc_debounce.sv ====
/*
 * Two-flop synchroniser and debounce filter for one pin.
 * Assumes the pin is asynchronous to clk and bounces for under 1 ms.
 */
`timescale 1ns/100ps

module tdc_debounce
    import tdc_pkg::*;
#(
    parameter int SETTLE_CYC = DEBOUNCE_CYC
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);

    logic              sync_a;
    logic              sync_b;
    logic [DB_W-1:0]   cnt;
    logic [DB_W-1:0]   next_cnt;
    logic              next_level;

    // Filter: level follows only after a stable run
    always_comb
    begin
        next_cnt   = '0;
        next_level = level;
        if (sync_b != level)
        begin
            next_cnt = cnt + 1'b1;
            if (cnt == DB_W'(SETTLE_CYC - 1))
            begin
                next_level = sync_b;
                next_cnt   = '0;
            end
        end
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt    <= '0;
            level  <= 1'b0;
        end
        else
        begin
            sync_a <= pin;
            sync_b <= sync_a;
            cnt    <= next_cnt;
            level  <= next_level;
        end
    end

endmodule // tdc_debounce

// ==== hw/tdc_pkg.sv ====
/*
 * Package for the multi-function time delay controller.
 * Assumes a 100 MHz clock; holds mode codes, timing constants and the
 * packed carriers for conditioned inputs.
 */
package tdc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CLK_MHZ        = 100;
    localparam int  PULSE_MS       = 500;          // Fixed pulse width
    localparam int  PULSE_CYC      = PULSE_MS * 1000 * CLK_MHZ;
    localparam int  DEBOUNCE_US    = 1000;
    localparam int  DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int  CNT_W          = 32;
    localparam int  DB_W           = 20;

    // ------------------------------------------------------------
    // Timing function select
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TDC_FN_ON_DELAY     = 3'h0,
        TDC_FN_CYCLE_OPEN   = 3'h1,
        TDC_FN_INTERVAL     = 3'h2,
        TDC_FN_OFF_DELAY    = 3'h3,
        TDC_FN_ONE_SHOT     = 3'h4,
        TDC_FN_CYCLE_CLOSED = 3'h5,
        TDC_FN_PULSE        = 3'h6
    } tdc_mode_t;

    // Sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        TDC_ST_IDLE  = 3'h0,
        TDC_ST_WAIT  = 3'h1,
        TDC_ST_ON    = 3'h3,
        TDC_ST_HOLD  = 3'h2,
        TDC_ST_OFF   = 3'h6,
        TDC_ST_DONE  = 3'h7
    } tdc_state_t;

    // Conditioned input carrier
    typedef struct packed {
        logic power;
        logic trig;
    } tdc_inputs_t;

endpackage : tdc_pkg

// ==== tb/tdc_ctrl_tb_top.sv ====
/*
 * Self-checking bench for the time delay controller.
 * Assumes the contact model in tdc_partner and a 100 MHz clock.
 */
`timescale 1ns/100ps

module tdc_ctrl_tb_top;
    import tdc_pkg::*;

    localparam int    DB_LEN   = 32;      // Short debounce for the run
    localparam int    PLS_LEN  = 50;      // Short fixed pulse for the run
    localparam int    LONG_DLY = 1000;    // Outlasts a settle wait
    localparam int    LO = DB_LEN;
    localparam int    HI = DB_LEN + 300;

    logic             clk;
    logic             rst;
    logic             power_req;
    logic             trig_req;
    logic             power_pin;
    logic             trigger_pin;
    tdc_mode_t        mode_sel;
    logic [CNT_W-1:0] delay_count;
    logic             relay_output;
    logic             timing_active;
    int               error_cnt;
    int               compares;
    int               n;

    tdc_partner prt (
        .clk         (clk),
        .power_req   (power_req),
        .trig_req    (trig_req),
        .power_pin   (power_pin),
        .trigger_pin (trigger_pin)
    );

    tdc_ctrl #(
        .SETTLE_CYC (DB_LEN),
        .PULSE_LEN  (PLS_LEN)
    ) uut (
        .clk           (clk),
        .rst           (rst),
        .power_pin     (power_pin),
        .trigger_pin   (trigger_pin),
        .mode_sel      (mode_sel),
        .delay_count   (delay_count),
        .relay_output  (relay_output),
        .timing_active (timing_active)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Free-running clock
    always #5 clk = ~clk;

    function automatic logic obs(input bit s);
        return s ? timing_active : relay_output;
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic pwr(input logic v);
        @(posedge clk);
        power_req <= v;
    endtask

    task automatic trig(input logic v);
        @(posedge clk);
        trig_req <= v;
    endtask

    task automatic setup(input tdc_mode_t m, input logic [CNT_W-1:0] d);
        @(posedge clk);
        mode_sel    <= m;
        delay_count <= d;
    endtask

    task automatic chk(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        chk(int'(got >= lo && got <= hi), 1);
        if (got < lo || got > hi)
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, lo);
    endtask

    // Cycles until a signal reaches a level, bounded
    task automatic wait_for(input bit s, input logic v, output int k);
        k = 0;
        while (obs(s) !== v && k < 400000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 400000)
            chk(k, 0);
    endtask

    // Cycles a signal holds a level, up to a limit
    task automatic len(input bit s, input logic v, input int lim,
                       output int k);
        k = 0;
        while (obs(s) === v && k < lim)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_on_delay;
        setup(TDC_FN_ON_DELAY, 32'h0000_0014);
        pwr(1'b1);
        trig(1'b1);
        wait_for(1'b1, 1'b1, n);
        len(1'b0, 1'b0, 400000, n);
        chk(n, 20);
        pwr(1'b0);
        wait_for(1'b0, 1'b0, n);
        chk_rng(n, LO, HI);
        chk_bit(timing_active, 1'b0);
        trig(1'b0);
        $display("on-delay test finished");
    endtask

    task automatic t_interval;
        setup(TDC_FN_INTERVAL, 32'h0000_0014);
        pwr(1'b1);
        wait_for(1'b0, 1'b1, n);
        chk_bit(timing_active, 1'b1);
        len(1'b0, 1'b1, 400000, n);
        chk(n, 20);
        pwr(1'b0);
        cyc(HI);
        setup(TDC_FN_INTERVAL, 32'h0003_d090);
        pwr(1'b1);
        wait_for(1'b0, 1'b1, n);
        pwr(1'b0);
        wait_for(1'b0, 1'b0, n);
        chk_rng(n, LO, HI);
        $display("interval test finished");
    endtask

    task automatic t_cycle(input tdc_mode_t m, input logic first);
        setup(m, 32'h0000_0014);
        pwr(1'b1);
        wait_for(1'b1, 1'b1, n);
        len(1'b0, first, 400000, n);
        chk(n, 20);
        len(1'b0, ~first, 400000, n);
        chk(n, 20);
        len(1'b0, first, 400000, n);
        chk(n, 20);
        trig(1'b1);
        cyc(HI);
        wait_for(1'b0, 1'b0, n);
        wait_for(1'b0, 1'b1, n);
        len(1'b0, 1'b1, 400000, n);
        chk(n, 20);
        len(1'b0, 1'b0, 400000, n);
        chk(n, 20);
        pwr(1'b0);
        trig(1'b0);
        wait_for(1'b0, 1'b0, n);
        cyc(HI);
        $display("repeat cycle test finished");
    endtask

    task automatic t_off_delay;
        setup(TDC_FN_OFF_DELAY, LONG_DLY);
        pwr(1'b1);
        cyc(HI);
        chk_bit(relay_output, 1'b0);
        trig(1'b1);
        wait_for(1'b0, 1'b1, n);
        chk_rng(n, LO, HI);
        trig(1'b0);
        cyc(HI);
        trig(1'b1);
        len(1'b0, 1'b1, 600, n);
        chk(n, 600);
        trig(1'b0);
        len(1'b0, 1'b1, 4000, n);
        chk_rng(n, LO + LONG_DLY, HI + LONG_DLY);
        trig(1'b1);
        wait_for(1'b0, 1'b1, n);
        pwr(1'b0);
        wait_for(1'b0, 1'b0, n);
        chk_rng(n, LO, HI);
        trig(1'b0);
        cyc(HI);
        $display("off-delay test finished");
    endtask

    task automatic t_one_shot;
        setup(TDC_FN_ONE_SHOT, LONG_DLY);
        trig(1'b1);
        len(1'b0, 1'b0, HI, n);
        chk(n, HI);
        pwr(1'b1);
        cyc(HI);
        trig(1'b0);
        cyc(HI);
        trig(1'b1);
        wait_for(1'b0, 1'b1, n);
        chk_rng(n, LO, HI);
        chk_bit(timing_active, 1'b1);
        trig(1'b0);
        cyc(HI);
        trig(1'b1);
        len(1'b0, 1'b1, 4000, n);
        chk_rng(n, LO + LONG_DLY, HI + LONG_DLY);
        pwr(1'b0);
        cyc(HI);
        trig(1'b0);
        $display("one-shot test finished");
    endtask

    task automatic t_pulse;
        setup(TDC_FN_PULSE, 32'h0000_0014);
        // Second pass shows the pulse again after a power cycle
        repeat (2)
        begin
            pwr(1'b1);
            wait_for(1'b1, 1'b1, n);
            len(1'b0, 1'b0, 400000, n);
            chk(n, 20);
            len(1'b0, 1'b1, 1000, n);
            chk(n, PLS_LEN);
            len(1'b0, 1'b0, HI, n);
            chk(n, HI);
            pwr(1'b0);
            cyc(HI);
        end
        $display("pulse test finished");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic final_report;
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        clk         = 1'b0;
        rst         = 1'b1;
        power_req   = 1'b0;
        trig_req    = 1'b0;
        mode_sel    = TDC_FN_ON_DELAY;
        delay_count = 32'h0000_0014;
        error_cnt   = 0;
        compares    = 0;
        cyc(2);
        rst <= 1'b0;
        cyc(HI);
        t_on_delay;
        t_interval;
        t_cycle(TDC_FN_CYCLE_OPEN, 1'b0);
        t_cycle(TDC_FN_CYCLE_CLOSED, 1'b1);
        t_off_delay;
        t_one_shot;
        t_pulse;
        final_report;
    end

    // Watchdog, well past the expected run length
    initial
    begin
        #500_000;
        error_cnt++;
        final_report;
    end

endmodule // tdc_ctrl_tb_top

// ==== tb/tdc_partner.sv ====
/*
 * Model of the supply-sense and trigger-switch contacts.
 * Assumes level requests from the bench, changed in the clk domain.
 */
`timescale 1ns/100ps

module tdc_partner
(
    input  wire logic clk,
    input  wire logic power_req,
    input  wire logic trig_req,
    output logic      power_pin,
    output logic      trigger_pin
);

    wire logic  [1:0] req;
    logic       [1:0] last;
    logic       [1:0] pins;
    logic       [5:0] bcnt [2];

    assign req         = {trig_req, power_req};
    assign power_pin   = pins[0];
    assign trigger_pin = pins[1];

    // Quiet contacts at time zero
    initial
    begin
        last    = 2'h0;
        pins    = 2'h0;
        bcnt[0] = 6'h00;
        bcnt[1] = 6'h00;
    end

    // Contacts chatter for 40 cycles after every change of request
    always @(posedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (req[i] !== last[i])
            begin
                last[i] <= req[i];
                bcnt[i] <= 6'h28;
            end
            else if (bcnt[i] != 6'h00)
                bcnt[i] <= bcnt[i] - 6'h01;
            pins[i] <= (bcnt[i] > 6'h01) ? (bcnt[i][2] ^ req[i]) : req[i];
        end
    end

endmodule // tdc_partner
